// ---- hdl/sdrc_defines.svh ----
`ifndef SDRC_DEFINES_SVH
`define SDRC_DEFINES_SVH
// Register word offsets, compared with haddr[7:2].
`define SDRC_OFS_STATUS 6'h00
`define SDRC_OFS_CONFIG 6'h01
`define SDRC_OFS_ISTAT 6'h02
`define SDRC_OFS_IMASK 6'h03
// Status register fields.
`define SDRC_ST_LOW 0
`define SDRC_ST_HOLD 1
// Configuration register fields.
`define SDRC_CF_PWRD 0
`define SDRC_CF_RSTD 1
`define SDRC_CF_STOPEN 2
`define SDRC_CF_TRIP 3
`define SDRC_CF_SHORT_RECOVERY_SELECT 4
`define SDRC_CF_RESET 5'h00
// Event bits of the interrupt status and mask registers.
`define SDRC_EV_RECOV 0
`define SDRC_EV_LPEXIT 1
`define SDRC_EV_W 2
`define SDRC_EV_RESET 2'h0
// Stop recovery lengths in oscillator cycles.
`define SDRC_RECOV_LONG 4096
`define SDRC_RECOV_SHORT 32
// Cycles during which a fresh 5-V selection may still force a reset.
`define SDRC_TRIP_SETTLE 2'h3
`define SDRC_RESET_VECTOR 16'hfffe
`endif

// ---- hdl/sdrc_pkg.sv ----
package sdrc_pkg;
  typedef enum logic [1:0] {
    SDRC_RUN = 2'b00,
    SDRC_STOP = 2'b01,
    SDRC_RECOVER = 2'b10
  } sdrc_lp_t;
endpackage : sdrc_pkg

// ---- hdl/sdrc_top.sv ----
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "sdrc_defines.svh"
module sdrc_top #(
  parameter int unsigned RECOV_LONG = `SDRC_RECOV_LONG,
  parameter int unsigned RECOV_SHORT = `SDRC_RECOV_SHORT
) (
  input wire logic core_clk, // Bus and oscillator clock.
  input wire logic rst_b, // Power-on reset, synchronous.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic below_falling_raw, // Comparator: supply below falling level.
  input wire logic above_rising_raw, // Comparator: supply above rising level.
  input wire logic wait_mode, // Core is in wait mode.
  input wire logic stop_mode, // Stop instruction request.
  input wire logic ext_wake, // External interrupt wake pulse.
  input wire logic sys_reset_seen, // Any system reset is active.
  output logic range_5v_sel, // Comparator threshold select.
  output logic dropout_reset, // Reset request to the reset controller.
  output logic rst_pin_o, // Reset pin drive value.
  output logic rst_pin_oe, // Reset pin output enable.
  output logic lp_exit_reset, // Dropout reset ended wait (level while both last) or stop (pulse).
  output logic clk_inhibit, // System clocks held off.
  output logic vec_load, // Pulse: load program counter from vector.
  output logic [15:0] vec_addr, // Vector address to load.
  output logic irq // Level interrupt.
);
  localparam logic [11:0] LONG_LD = 12'(RECOV_LONG - 1);
  localparam logic [11:0] SHORT_LD = 12'(RECOV_SHORT - 1);

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic below_s;
  logic above_s;
  logic cfg_pwrd;
  logic cfg_rstd;
  logic cfg_stop_en;
  logic cfg_short_recovery_select;
  logic low_flag;
  logic [1:0] trip_pend;
  logic [`SDRC_EV_W-1:0] istat;
  logic [`SDRC_EV_W-1:0] imask;
  logic [`SDRC_EV_W-1:0] ev;
  logic [11:0] rec_cnt;
  logic ap_valid;
  logic ap_write;
  logic [5:0] ap_idx;
  logic wr_cfg;
  logic mon_active;
  logic trip_force;
  logic stop_exit_rst;
  sdrc_pkg::sdrc_lp_t state;
  sdrc_pkg::sdrc_lp_t next_state;

  // The comparator switches at its own pace, so a raw edge may land inside the
  // setup window of the first flop; only the second flop is ever read.
  // Two-stage synchroniser.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= (i == 0) ? below_falling_raw : above_rising_raw;
        sync_b[i] <= sync_a[i];
      end
    end
  end
  assign below_s = sync_b[0];
  assign above_s = sync_b[1];

  assign mon_active = !cfg_pwrd && (state != sdrc_pkg::SDRC_STOP || cfg_stop_en);
  assign trip_force = (trip_pend != 2'h0) && !above_s;

  // Zero-wait slave: address phase captured, write applied in data phase.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_idx <= 6'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_idx <= haddr[7:2];
    end
  end
  assign wr_cfg = ap_valid && ap_write && ap_idx == `SDRC_OFS_CONFIG;

  // Read data is loaded at the address phase so it stands through the data phase.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite) begin
        unique case (haddr[7:2])
          `SDRC_OFS_STATUS: hrdata <= {30'h0, dropout_reset, low_flag};
          `SDRC_OFS_CONFIG: hrdata <= {27'h0, cfg_short_recovery_select, range_5v_sel, cfg_stop_en,
                                       cfg_rstd, cfg_pwrd};
          `SDRC_OFS_ISTAT: hrdata <= {30'h0, istat};
          `SDRC_OFS_IMASK: hrdata <= {30'h0, imask};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_pwrd <= 1'b0;
      cfg_rstd <= 1'b0;
      cfg_stop_en <= 1'b0;
      range_5v_sel <= 1'b0;
      cfg_short_recovery_select <= 1'b0;
    end else if (wr_cfg) begin
      cfg_pwrd <= hwdata[`SDRC_CF_PWRD];
      cfg_rstd <= hwdata[`SDRC_CF_RSTD];
      cfg_stop_en <= hwdata[`SDRC_CF_STOPEN];
      range_5v_sel <= hwdata[`SDRC_CF_TRIP];
      cfg_short_recovery_select <= hwdata[`SDRC_CF_SHORT_RECOVERY_SELECT];
    end
  end

  // The comparator needs the sync delay to see the new threshold, so a
  // fresh 5-V choice watches the rising result for a few cycles.
  // Three cycles is the least that works: two synchroniser edges, then the decision.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trip_pend <= 2'h0;
    end else if (wr_cfg && hwdata[`SDRC_CF_TRIP] && !range_5v_sel) begin
      trip_pend <= `SDRC_TRIP_SETTLE;
    end else if (trip_pend != 2'h0) begin
      trip_pend <= trip_pend - 2'h1;
    end
  end

  // A disabled monitor lets go of its reset, since its comparator no
  // longer counts.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dropout_reset <= 1'b0;
      rst_pin_oe <= 1'b0;
      rst_pin_o <= 1'b0;
    end else begin
      rst_pin_o <= 1'b0;
      if (mon_active && !cfg_rstd && (below_s || trip_force)) begin
        dropout_reset <= 1'b1;
        rst_pin_oe <= 1'b1;
      end else if (above_s || !mon_active) begin
        dropout_reset <= 1'b0;
        rst_pin_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      low_flag <= 1'b0;
    end else if (mon_active && below_s) begin
      low_flag <= 1'b1;
    end else if (sys_reset_seen || (mon_active && above_s)) begin
      low_flag <= 1'b0;
    end
  end

  assign stop_exit_rst = state == sdrc_pkg::SDRC_STOP && dropout_reset;

  always_comb begin
    next_state = state;
    unique case (state)
      sdrc_pkg::SDRC_RUN: if (stop_mode) next_state = sdrc_pkg::SDRC_STOP;
      sdrc_pkg::SDRC_STOP: if (dropout_reset || ext_wake) next_state = sdrc_pkg::SDRC_RECOVER;
      sdrc_pkg::SDRC_RECOVER: if (rec_cnt == 12'h000) next_state = sdrc_pkg::SDRC_RUN;
      default: next_state = sdrc_pkg::SDRC_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= sdrc_pkg::SDRC_RUN;
      rec_cnt <= 12'h000;
      clk_inhibit <= 1'b0;
    end else begin
      state <= next_state;
      clk_inhibit <= next_state != sdrc_pkg::SDRC_RUN;
      if (state == sdrc_pkg::SDRC_STOP) begin
        rec_cnt <= cfg_short_recovery_select ? SHORT_LD : LONG_LD;
      end else if (rec_cnt != 12'h000) begin
        rec_cnt <= rec_cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      vec_load <= 1'b0;
      vec_addr <= `SDRC_RESET_VECTOR;
      lp_exit_reset <= 1'b0;
    end else begin
      vec_load <= stop_exit_rst;
      vec_addr <= `SDRC_RESET_VECTOR;
      lp_exit_reset <= stop_exit_rst || (wait_mode && dropout_reset);
    end
  end

  assign ev[`SDRC_EV_RECOV] = state == sdrc_pkg::SDRC_RECOVER && rec_cnt == 12'h000;
  assign ev[`SDRC_EV_LPEXIT] = stop_exit_rst || (wait_mode && dropout_reset);

  // A new event beats a clearing write in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      istat <= `SDRC_EV_RESET;
      imask <= `SDRC_EV_RESET;
      irq <= 1'b0;
    end else begin
      if (ap_valid && ap_write && ap_idx == `SDRC_OFS_ISTAT) begin
        istat <= (istat & ~hwdata[`SDRC_EV_W-1:0]) | ev;
      end else begin
        istat <= istat | ev;
      end
      if (ap_valid && ap_write && ap_idx == `SDRC_OFS_IMASK) begin
        imask <= hwdata[`SDRC_EV_W-1:0];
      end
      irq <= |(istat & imask);
    end
  end

  // Helper logic for the recovery length check.
  logic [12:0] rec_cycles;
  logic [12:0] rec_target;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rec_cycles <= 13'h0000;
      rec_target <= 13'h0000;
    end else begin
      rec_cycles <= (state == sdrc_pkg::SDRC_RECOVER) ? rec_cycles + 13'h0001 : 13'h0000;
      if (state == sdrc_pkg::SDRC_STOP) begin
        rec_target <= cfg_short_recovery_select ? 13'(RECOV_SHORT) : 13'(RECOV_LONG);
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence stop_reset_wake;
    state == sdrc_pkg::SDRC_STOP && dropout_reset ##1 state == sdrc_pkg::SDRC_RECOVER;
  endsequence

  // A 5-V pick whose new result reaches the decision edge with the supply still low.
  sequence five_volt_pick;
    wr_cfg && hwdata[`SDRC_CF_TRIP] && !range_5v_sel && !cfg_pwrd && !hwdata[`SDRC_CF_RSTD]
      ##3 (!above_s && mon_active && !cfg_rstd);
  endsequence

  // Checks look one edge past each decision, since every output is registered.

  por_enable_a: assert property ($rose(rst_b) |-> !cfg_pwrd && !range_5v_sel)
    else $error("monitor not enabled in 3-V range after reset");
  pwrd_ignore_a: assert property (cfg_pwrd && !dropout_reset |=> !dropout_reset)
    else $error("disabled monitor raised reset");
  reset_raise_a: assert property (mon_active && !cfg_rstd && below_s |=> dropout_reset)
    else $error("dropout reset missing");
  range_follow_a: assert property (wr_cfg |=> range_5v_sel == $past(hwdata[`SDRC_CF_TRIP]))
    else $error("range select does not follow write");
  trip_force_a: assert property (five_volt_pick |=> dropout_reset)
    else $error("5-V select did not force reset");
  hyst_hold_a: assert property (dropout_reset && mon_active && !above_s |=> dropout_reset)
    else $error("reset released below rising level");
  pin_drive_a: assert property (rst_pin_oe == dropout_reset && !rst_pin_o)
    else $error("reset pin not driven with dropout reset");
  flag_hyst_a: assert property (mon_active && !below_s && !above_s && !sys_reset_seen
    |=> $stable(low_flag)) else $error("low flag changed between levels");
  flag_clear_a: assert property (sys_reset_seen && !(mon_active && below_s) |=> !low_flag)
    else $error("system reset left low flag set");
  no_irq_a: assert property (irq |-> $past(|(istat & imask)))
    else $error("interrupt without unmasked event");
  wait_exit_a: assert property (wait_mode && dropout_reset |=> lp_exit_reset)
    else $error("wait not ended by dropout reset");
  stop_quiet_a: assert property (state == sdrc_pkg::SDRC_STOP && !cfg_stop_en
    && !dropout_reset |=> !dropout_reset) else $error("monitor active in stop");
  stop_vector_a: assert property (stop_reset_wake |-> vec_load
    && vec_addr == `SDRC_RESET_VECTOR && clk_inhibit) else $error("no vector load on exit");
  recov_len_a: assert property (state == sdrc_pkg::SDRC_RUN
    && $past(state) == sdrc_pkg::SDRC_RECOVER |-> rec_cycles == rec_target)
    else $error("stop recovery length wrong");
  release_above_a: assert property (dropout_reset && above_s && !below_s
    && !trip_force |=> !dropout_reset) else $error("reset held above rising level");
  flag_set_a: assert property (mon_active && below_s |=> low_flag)
    else $error("low flag not set below falling level");
  flag_drop_a: assert property (mon_active && above_s && !below_s |=> !low_flag)
    else $error("low flag not cleared above rising level");
  quiet_events_a: assert property (ev == 2'h0 |=> (istat & ~$past(istat)) == 2'h0)
    else $error("event bit set without a sequencer event");
  stop_awake_a: assert property (state == sdrc_pkg::SDRC_STOP && cfg_stop_en
    && !cfg_pwrd && !cfg_rstd && below_s |=> dropout_reset)
    else $error("stop-enabled monitor missed low supply");
  sync_delay_a: assert property ($past(rst_b, 2) |-> sync_b
    == {$past(above_rising_raw, 2), $past(below_falling_raw, 2)})
    else $error("synchroniser delay wrong");
endmodule : sdrc_top

// ---- verification/sdrc_comp_model.sv ----
`timescale 1ns/100ps
module sdrc_comp_model #(
  parameter int FALL_3V = 2600,
  parameter int RISE_3V = 2700,
  parameter int FALL_5V = 4200,
  parameter int RISE_5V = 4300
) (
  input wire logic [15:0] supply_mv, // Supply level in millivolts.
  input wire logic range_5v_sel, // Threshold set select.
  output logic below_falling_raw, // Supply below falling level.
  output logic above_rising_raw // Supply above rising level.
);
  always_comb begin
    below_falling_raw = int'(supply_mv) < (range_5v_sel ? FALL_5V : FALL_3V);
    above_rising_raw = int'(supply_mv) > (range_5v_sel ? RISE_5V : RISE_3V);
  end
endmodule : sdrc_comp_model

// ---- verification/supply_dropout_reset_control_tb.sv ----
`timescale 1ns/100ps
module supply_dropout_reset_control_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic ext_wake = 1'b0;
  logic sys_reset_seen = 1'b0;
  logic [15:0] supply_mv = 16'h0ce4;
  logic vec_seen = 1'b0;
  logic hreadyout, hresp, below, above, range_5v_sel, dropout_reset, rst_pin_o, rst_pin_oe;
  logic lp_exit_reset, clk_inhibit, vec_load, irq;
  logic [31:0] hrdata;
  logic [15:0] vec_addr;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  sdrc_top #(.RECOV_LONG(64), .RECOV_SHORT(8)) u_sdrc_top (.core_clk(core_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .below_falling_raw(below), .above_rising_raw(above), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .ext_wake(ext_wake), .sys_reset_seen(sys_reset_seen),
    .range_5v_sel(range_5v_sel), .dropout_reset(dropout_reset), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .lp_exit_reset(lp_exit_reset), .clk_inhibit(clk_inhibit),
    .vec_load(vec_load), .vec_addr(vec_addr), .irq(irq));
  sdrc_comp_model u_sdrc_comp_model (.supply_mv(supply_mv), .range_5v_sel(range_5v_sel),
    .below_falling_raw(below), .above_rising_raw(above));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (vec_load === 1'b1) begin
      vec_seen <= 1'b1;
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Hangs end here; the whole run needs a few hundred cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task rc(input string name, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(name, e, q);
  endtask : rc

  // Comparator changes need three edges to reach the reset output.
  task settle(input logic [15:0] mv);
    @(posedge core_clk);
    supply_mv <= mv;
    repeat (6) @(posedge core_clk);
  endtask : settle

  // Counts the cycles that the clocks stay held after the exit event is taken.
  task recover(input int e);
    int k;
    int n;
    k = 0;
    n = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (dropout_reset !== 1'b1 && ext_wake !== 1'b1 && k < 50);
    ext_wake <= 1'b0;
    while (n < 5000) begin
      @(posedge core_clk);
      if (clk_inhibit !== 1'b1) break;
      n++;
    end
    chk("recovery", e, n);
  endtask : recover

  // Supply levels are in millivolts: 09c4 and 0a5a lie below and between the
  // 3-V levels, 0af0 and 0ce4 above them, 109a between the 5-V levels.
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rc("status", 32'h0, 32'h0);
    rc("config", 32'h4, 32'h0);
    chk("range_5v_sel", 32'h0, {31'h0, range_5v_sel});
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(32'h10, 32'hffffffff);
    rc("unmapped", 32'h10, 32'h0);
    $display("test reset values done");
    settle(16'h09c4);
    chk("dropout_reset", 32'h1, {31'h0, dropout_reset});
    chk("rst_pin_oe", 32'h1, {31'h0, rst_pin_oe});
    chk("rst_pin_o", 32'h0, {31'h0, rst_pin_o});
    rc("status", 32'h0, 32'h3);
    settle(16'h0a5a);
    chk("dropout_reset", 32'h1, {31'h0, dropout_reset});
    rc("status", 32'h0, 32'h3);
    settle(16'h0af0);
    chk("dropout_reset", 32'h0, {31'h0, dropout_reset});
    rc("status", 32'h0, 32'h0);
    $display("test forced reset done");
    wr(32'h4, 32'h2);
    settle(16'h09c4);
    chk("dropout_reset", 32'h0, {31'h0, dropout_reset});
    rc("status", 32'h0, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    settle(16'h0a5a);
    sys_reset_seen <= 1'b1;
    @(posedge core_clk);
    sys_reset_seen <= 1'b0;
    rc("status", 32'h0, 32'h0);
    wr(32'h4, 32'h1);
    settle(16'h09c4);
    chk("dropout_reset", 32'h0, {31'h0, dropout_reset});
    rc("status", 32'h0, 32'h0);
    $display("test polled and disabled done");
    wr(32'h4, 32'h0);
    // Between the 5-V levels only the fresh selection can force the reset.
    settle(16'h109a);
    wr(32'h4, 32'h8);
    repeat (6) @(posedge core_clk);
    chk("range_5v_sel", 32'h1, {31'h0, range_5v_sel});
    chk("dropout_reset", 32'h1, {31'h0, dropout_reset});
    settle(16'h1130);
    chk("dropout_reset", 32'h0, {31'h0, dropout_reset});
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rc("config", 32'h4, 32'h0);
    chk("range_5v_sel", 32'h0, {31'h0, range_5v_sel});
    $display("test range select done");
    wait_mode <= 1'b1;
    settle(16'h09c4);
    chk("lp_exit_reset", 32'h1, {31'h0, lp_exit_reset});
    wait_mode <= 1'b0;
    settle(16'h0ce4);
    stop_mode <= 1'b1;
    @(posedge core_clk);
    stop_mode <= 1'b0;
    settle(16'h09c4);
    chk("dropout_reset", 32'h0, {31'h0, dropout_reset});
    chk("clk_inhibit", 32'h1, {31'h0, clk_inhibit});
    ext_wake <= 1'b1;
    recover(64);
    chk("vec_seen", 32'h0, {31'h0, vec_seen});
    // Bit one was set when the dropout reset ended wait mode.
    rc("istat", 32'h8, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(32'hc, 32'h1);
    rc("istat", 32'h8, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(32'h8, 32'h1);
    rc("istat", 32'h8, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(32'h8, 32'h2);
    rc("istat", 32'h8, 32'h0);
    settle(16'h0ce4);
    wr(32'h4, 32'h14);
    stop_mode <= 1'b1;
    @(posedge core_clk);
    stop_mode <= 1'b0;
    supply_mv <= 16'h09c4;
    recover(8);
    chk("vec_seen", 32'h1, {31'h0, vec_seen});
    chk("vec_addr", 32'hfffe, {16'h0, vec_addr});
    rc("istat", 32'h8, 32'h3);
    $display("test low-power modes done");
    final_report();
  end
endmodule : supply_dropout_reset_control_tb
